// ==== rtl/dcm_consts.vh ====
// opcode match values, register offsets, status fields, reset values
// assumes it is included by the decoder only, by its bare name
`ifndef DCM_CONSTS_VH
`define DCM_CONSTS_VH
// opcode prefixes, compared against the named slice
`define DCM_OP_BIT   4'h4
`define DCM_OP_BITIDX 8'h6F
`define DCM_OP_FLAG  12'hBE4
`define DCM_OP_IDLE  16'hBE22
`define DCM_OP_SLEEP 16'hBE23
`define DCM_OP_STLD  7'h07
`define DCM_OP_STSV  7'h47
`define DCM_OP_POP   16'hBE32
`define DCM_OP_POPMEM 8'h8A
`define DCM_OP_PUSHMEM 8'h76
`define DCM_OP_PUSH  16'hBE3C
`define DCM_OP_RPTD  8'h0B
`define DCM_OP_RPTL  16'hBEC4
`define DCM_OP_RPTS  8'hBB
`define DCM_OP_ZLOOP 16'hBEC5
`define DCM_OP_MPYK  3'h6
`define DCM_OP_MULS  8'h54
`define DCM_OP_MULU  8'h55
`define DCM_OP_SQACC 8'h52
`define DCM_OP_MACBLK 8'hAB
`define DCM_OP_PSHIFT 14'h2FC0
// flag select codes in opcode bits 3..1
`define DCM_F_IMASK  3'h0
`define DCM_F_OVM    3'h1
`define DCM_F_RAMCFG 3'h2
`define DCM_F_SXM    3'h3
`define DCM_F_HM     3'h4
`define DCM_F_TFLAG  3'h5
`define DCM_F_EXTPIN 3'h6
`define DCM_F_C    3'h7
// register byte offsets
`define DCM_R_ACCL 8'h00
`define DCM_R_ACCH 8'h04
`define DCM_R_PRGL 8'h08
`define DCM_R_PRGH 8'h0C
`define DCM_R_MCND 8'h10
`define DCM_R_BIDX 8'h14
`define DCM_R_BLKA 8'h18
`define DCM_R_AUX  8'h1C
`define DCM_R_ST0  8'h20
`define DCM_R_ST1  8'h24
`define DCM_R_RCNT 8'h28
`define DCM_R_STAT 8'h2C
// status word field positions
`define DCM_ST0_OVM  11
`define DCM_ST0_IMASK  9
`define DCM_ST1_RAMCFG 12
`define DCM_ST1_TFLAG  11
`define DCM_ST1_SXM  10
`define DCM_ST1_C    9
`define DCM_ST1_HM   6
`define DCM_ST1_EXTPIN 4
// reset values
`define DCM_RST_IMASK 1'b1
`define DCM_RST_FLAG 1'b0
`define DCM_RST_W16  16'h0000
`define DCM_RST_W32  32'h00000000
`endif

// ==== rtl/dcm_decoder.v ====
// control and multiply instruction decoder/executor
// assumes program memory on CLK_SYS with valid/ready,
// data memory answering a read one cycle after DM_RD
`timescale 1ns/1ps
`default_nettype none
`include "dcm_consts.vh"
module dcm_decoder (
  input  wire        CLK_SYS,
  input  wire        RSTN,
  input  wire [15:0] INSTR_WORD,
  input  wire        INSTR_VALID,
  output reg         INSTR_READY,
  output reg  [15:0] DM_ADDR,
  output reg         DM_RD,
  output reg         DM_WR,
  output reg  [15:0] DM_WDATA,
  input  wire [15:0] DM_RDATA,
  output reg  [15:0] PM_ADDR,
  output reg         PM_RD,
  input  wire [15:0] PM_RDATA,
  input  wire        INT_REQ,
  output reg         EXT_FLAG_PIN,
  output reg         IDLE_ACT,
  output reg         LOW_POWER,
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [31:0] REG_RDATA
);
  localparam [2:0] S_FETCH = 3'h0;
  localparam [2:0] S_ISSUE = 3'h1;
  localparam [2:0] S_MEM   = 3'h2;
  localparam [2:0] S_EXEC  = 3'h3;
  localparam [2:0] S_WAIT  = 3'h4;
  localparam [2:0] S_WORD2 = 3'h5;
  localparam [2:0] S_IDLE  = 3'h6;

  reg [2:0]  state_r,  state_nxt;
  reg [15:0] instr_r,  instr_nxt;
  reg [31:0] sum_r,    sum_nxt;
  reg [31:0] prod_r,   prod_nxt;
  reg [15:0] treg_r,   treg_nxt;
  reg [15:0] tidx_r,   tidx_nxt;
  reg [15:0] blka_r,   blka_nxt;
  reg [15:0] aux_r,    aux_nxt;
  reg [8:0]  dp_r,     dp_nxt;
  reg        ovm_r,    ovm_nxt;
  reg        imask_r,  imask_nxt;
  reg        ramcfg_r, ramcfg_nxt;
  reg        sxm_r,    sxm_nxt;
  reg        hm_r,     hm_nxt;
  reg        tflag_r,  tflag_nxt;
  reg        c_r,      c_nxt;
  reg [1:0]  pmode_r,  pmode_nxt;
  reg [2:0]  sp_r,     sp_nxt;
  reg [15:0] rcnt_r,   rcnt_nxt;
  reg        rarm_r,   rarm_nxt;
  reg        ract_r,   ract_nxt;
  reg        int_s1_r;
  reg        int_s2_r;
  reg        ready_nxt;
  reg [15:0] dm_addr_nxt;
  reg        dm_rd_nxt;
  reg        dm_wr_nxt;
  reg [15:0] dm_wdata_nxt;
  reg [15:0] pm_addr_nxt;
  reg        pm_rd_nxt;
  reg        pin_nxt;
  reg        idle_nxt;
  reg        lowp_nxt;
  reg [31:0] rdata_nxt;
  reg        stk_we;
  reg [2:0]  stk_wa;
  reg [15:0] stk_wd;
  reg        done;
  reg [31:0] psh;
  reg [15:0] stk [0:7];

  // instruction under decode: live word on fetch, latched word otherwise
  wire        fetch = (state_r == S_FETCH) && INSTR_VALID && INSTR_READY;
  wire        issue = fetch || (state_r == S_ISSUE);
  wire [15:0] cur   = (state_r == S_FETCH) ? INSTR_WORD : instr_r;
  wire        rep_now = fetch ? rarm_r : ract_r;

  // opcode decode
  wire d_bit   = cur[15:12] == `DCM_OP_BIT;
  wire d_bitidx  = cur[15:8]  == `DCM_OP_BITIDX;
  wire d_flag    = cur[15:4]  == `DCM_OP_FLAG;
  wire d_idle    = cur        == `DCM_OP_IDLE;
  wire d_sleep   = cur        == `DCM_OP_SLEEP;
  wire d_stld    = cur[15:9]  == `DCM_OP_STLD;
  wire d_stsv    = cur[15:9]  == `DCM_OP_STSV;
  wire d_pop     = cur        == `DCM_OP_POP;
  wire d_popmem  = cur[15:8]  == `DCM_OP_POPMEM;
  wire d_pushmem = cur[15:8]  == `DCM_OP_PUSHMEM;
  wire d_push    = cur        == `DCM_OP_PUSH;
  wire d_rptd    = cur[15:8]  == `DCM_OP_RPTD;
  wire d_rptl    = cur        == `DCM_OP_RPTL;
  wire d_rpts    = cur[15:8]  == `DCM_OP_RPTS;
  wire d_zloop   = cur        == `DCM_OP_ZLOOP;
  wire d_mpyk    = cur[15:13] == `DCM_OP_MPYK;
  wire d_muls    = cur[15:8]  == `DCM_OP_MULS;
  wire d_mulu    = cur[15:8]  == `DCM_OP_MULU;
  wire d_sqacc   = cur[15:8]  == `DCM_OP_SQACC;
  wire d_macblk  = cur[15:8]  == `DCM_OP_MACBLK;
  wire d_pshift  = cur[15:2]  == `DCM_OP_PSHIFT;

  // ops that fetch a data operand before executing
  wire rd_need = d_bit | d_bitidx | d_stld | d_pushmem | d_rptd |
                 d_muls | d_mulu | d_sqacc | d_macblk;

  // operand address: indirect through aux, else page plus offset
  wire [15:0] opaddr = cur[7] ? aux_r : {dp_r, cur[6:0]};

  // status words as seen by store and register reads
  wire [15:0] st0 = {4'h0, ovm_r, 1'b0, imask_r, dp_r};
  wire [15:0] st1 = {3'h0, ramcfg_r, tflag_r, sxm_r, c_r, 2'h0,
                     hm_r, 1'b0, EXT_FLAG_PIN, 4'h0};

  // stack top and neighbouring pointers
  wire [2:0]  sp_dn   = sp_r - 3'h1;
  wire [2:0]  sp_up   = sp_r + 3'h1;
  wire [15:0] stk_top = stk[sp_dn];

  // multiplier paths
  wire signed [15:0] k13   = {{3{cur[12]}}, cur[12:0]};
  wire signed [31:0] p_k   = $signed(treg_r) * k13;
  wire signed [31:0] p_s   = $signed(treg_r) * $signed(DM_RDATA);
  wire        [31:0] p_u   = {16'h0000, treg_r} * {16'h0000, DM_RDATA};
  wire signed [31:0] p_sq  = $signed(DM_RDATA) * $signed(DM_RDATA);
  wire signed [31:0] p_cf  = $signed(DM_RDATA) * $signed(PM_RDATA);

  // product shifter on the way into the sum register
  always @*
  begin
    case (pmode_r)
      2'h0:    psh = prod_r;
      2'h1:    psh = {prod_r[30:0], 1'b0};
      2'h2:    psh = {prod_r[27:0], 4'h0};
      default: psh = {{6{prod_r[31]}}, prod_r[31:6]};
    endcase
  end

  // next-state and datapath
  always @*
  begin
    state_nxt    = state_r;
    instr_nxt    = instr_r;
    sum_nxt      = sum_r;
    prod_nxt     = prod_r;
    treg_nxt     = treg_r;
    tidx_nxt     = tidx_r;
    blka_nxt     = blka_r;
    aux_nxt      = aux_r;
    dp_nxt       = dp_r;
    ovm_nxt      = ovm_r;
    imask_nxt    = imask_r;
    ramcfg_nxt   = ramcfg_r;
    sxm_nxt      = sxm_r;
    hm_nxt       = hm_r;
    tflag_nxt    = tflag_r;
    c_nxt        = c_r;
    pmode_nxt    = pmode_r;
    sp_nxt       = sp_r;
    rcnt_nxt     = rcnt_r;
    rarm_nxt     = rarm_r;
    ract_nxt     = ract_r;
    dm_addr_nxt  = DM_ADDR;
    dm_rd_nxt    = 1'b0;
    dm_wr_nxt    = 1'b0;
    dm_wdata_nxt = DM_WDATA;
    pm_addr_nxt  = PM_ADDR;
    pm_rd_nxt    = 1'b0;
    pin_nxt      = EXT_FLAG_PIN;
    idle_nxt     = IDLE_ACT;
    lowp_nxt     = LOW_POWER;
    stk_we       = 1'b0;
    stk_wa       = sp_r;
    stk_wd       = 16'h0000;
    done         = 1'b0;
    // software writes; instruction effects below take precedence
    if (REG_WR)
    begin
      case (REG_ADDR)
        `DCM_R_ACCL: sum_nxt[15:0]  = REG_WDATA[15:0];
        `DCM_R_ACCH: sum_nxt[31:16] = REG_WDATA[15:0];
        `DCM_R_PRGL: prod_nxt[15:0] = REG_WDATA[15:0];
        `DCM_R_PRGH: prod_nxt[31:16] = REG_WDATA[15:0];
        `DCM_R_MCND: treg_nxt = REG_WDATA[15:0];
        `DCM_R_BIDX: tidx_nxt = REG_WDATA[15:0];
        `DCM_R_BLKA: blka_nxt = REG_WDATA[15:0];
        `DCM_R_AUX:  aux_nxt  = REG_WDATA[15:0];
        `DCM_R_ST0:
        begin
          ovm_nxt   = REG_WDATA[`DCM_ST0_OVM];
          imask_nxt = REG_WDATA[`DCM_ST0_IMASK];
          dp_nxt    = REG_WDATA[8:0];
        end
        `DCM_R_ST1:
        begin
          ramcfg_nxt = REG_WDATA[`DCM_ST1_RAMCFG];
          tflag_nxt  = REG_WDATA[`DCM_ST1_TFLAG];
          sxm_nxt    = REG_WDATA[`DCM_ST1_SXM];
          c_nxt      = REG_WDATA[`DCM_ST1_C];
          hm_nxt     = REG_WDATA[`DCM_ST1_HM];
          pin_nxt    = REG_WDATA[`DCM_ST1_EXTPIN];
        end
        default: ;
      endcase
    end
    if (fetch)
    begin
      instr_nxt = INSTR_WORD;
      ract_nxt  = rarm_r;
      rarm_nxt  = 1'b0;
    end
    // first phase of any instruction, from fetch or replay
    if (issue)
    begin
      if (rd_need)
      begin
        dm_rd_nxt   = 1'b1;
        dm_addr_nxt = opaddr;
        pm_rd_nxt   = d_macblk;
        pm_addr_nxt = blka_r;
        state_nxt   = S_MEM;
      end
      else if (d_idle || d_sleep)
      begin
        idle_nxt  = 1'b1;
        lowp_nxt  = d_sleep;
        state_nxt = S_IDLE;
      end
      else if (d_rpts)
      begin
        rcnt_nxt  = {8'h00, cur[7:0]};
        rarm_nxt  = 1'b1;
        state_nxt = S_WAIT;
      end
      else if (d_rptl || d_zloop)
      begin
        if (d_zloop)
        begin
          sum_nxt  = 32'h00000000;
          prod_nxt = 32'h00000000;
        end
        state_nxt = S_WORD2;
      end
      else
      begin
        done = 1'b1;
        if (d_flag)
        begin
          case (cur[3:1])
            `DCM_F_IMASK:  imask_nxt  = cur[0];
            `DCM_F_OVM:    ovm_nxt    = cur[0];
            `DCM_F_RAMCFG: ramcfg_nxt = cur[0];
            `DCM_F_SXM:    sxm_nxt    = cur[0];
            `DCM_F_HM:     hm_nxt     = cur[0];
            `DCM_F_TFLAG:  tflag_nxt  = cur[0];
            `DCM_F_EXTPIN: pin_nxt    = cur[0];
            default:     c_nxt    = cur[0];
          endcase
        end
        if (d_stsv)
        begin
          dm_wr_nxt    = 1'b1;
          dm_addr_nxt  = opaddr;
          dm_wdata_nxt = cur[8] ? st1 : st0;
        end
        if (d_pop)
        begin
          sum_nxt[15:0] = stk_top;
          sp_nxt        = sp_dn;
        end
        if (d_popmem)
        begin
          dm_wr_nxt    = 1'b1;
          dm_addr_nxt  = opaddr;
          dm_wdata_nxt = stk_top;
          sp_nxt       = sp_dn;
        end
        if (d_push)
        begin
          stk_we = 1'b1;
          stk_wd = sum_r[15:0];
          sp_nxt = sp_up;
        end
        if (d_mpyk)
          prod_nxt = p_k;
        if (d_pshift)
          pmode_nxt = cur[1:0];
      end
    end
    // remaining phases
    case (state_r)
      S_FETCH: ;
      S_ISSUE: ;
      S_MEM:
        state_nxt = S_EXEC;
      S_EXEC:
      begin
        done = 1'b1;
        if (d_bit)
          tflag_nxt = DM_RDATA[~cur[11:8]];
        if (d_bitidx)
          tflag_nxt = DM_RDATA[~tidx_r[3:0]];
        if (d_stld && !cur[8])
        begin
          ovm_nxt   = DM_RDATA[`DCM_ST0_OVM];
          imask_nxt = DM_RDATA[`DCM_ST0_IMASK];
          dp_nxt    = DM_RDATA[8:0];
        end
        if (d_stld && cur[8])
        begin
          ramcfg_nxt = DM_RDATA[`DCM_ST1_RAMCFG];
          tflag_nxt  = DM_RDATA[`DCM_ST1_TFLAG];
          sxm_nxt    = DM_RDATA[`DCM_ST1_SXM];
          c_nxt      = DM_RDATA[`DCM_ST1_C];
          hm_nxt     = DM_RDATA[`DCM_ST1_HM];
          pin_nxt    = DM_RDATA[`DCM_ST1_EXTPIN];
        end
        if (d_pushmem)
        begin
          stk_we = 1'b1;
          stk_wd = DM_RDATA;
          sp_nxt = sp_up;
        end
        if (d_rptd)
        begin
          rcnt_nxt = DM_RDATA;
          rarm_nxt = 1'b1;
        end
        if (d_muls)
          prod_nxt = p_s;
        if (d_mulu)
          prod_nxt = p_u;
        if (d_sqacc || d_macblk)
        begin
          sum_nxt  = sum_r + psh;
          treg_nxt = DM_RDATA;
        end
        if (d_sqacc)
          prod_nxt = p_sq;
        if (d_macblk)
          prod_nxt = p_cf;
      end
      S_WAIT:
        state_nxt = S_FETCH;
      S_WORD2:
      begin
        if (INSTR_VALID && INSTR_READY)
        begin
          rcnt_nxt  = INSTR_WORD;
          rarm_nxt  = 1'b1;
          state_nxt = S_FETCH;
        end
      end
      S_IDLE:
      begin
        if (int_s2_r)
        begin
          idle_nxt  = 1'b0;
          lowp_nxt  = 1'b0;
          state_nxt = S_FETCH;
        end
      end
      default:
        state_nxt = S_FETCH;
    endcase
    // end of an instruction: replay while a repeat is running
    if (done)
    begin
      if (rep_now && (rcnt_r != 16'h0000))
      begin
        rcnt_nxt  = rcnt_r - 16'h0001;
        state_nxt = S_ISSUE;
      end
      else
      begin
        ract_nxt  = 1'b0;
        state_nxt = S_FETCH;
      end
    end
    ready_nxt = (state_nxt == S_FETCH) || (state_nxt == S_WORD2);
  end

  // register read mux, answer valid the cycle after the strobe
  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (REG_RD)
    begin
      case (REG_ADDR)
        `DCM_R_ACCL: rdata_nxt = {16'h0000, sum_r[15:0]};
        `DCM_R_ACCH: rdata_nxt = {16'h0000, sum_r[31:16]};
        `DCM_R_PRGL: rdata_nxt = {16'h0000, prod_r[15:0]};
        `DCM_R_PRGH: rdata_nxt = {16'h0000, prod_r[31:16]};
        `DCM_R_MCND: rdata_nxt = {16'h0000, treg_r};
        `DCM_R_BIDX: rdata_nxt = {16'h0000, tidx_r};
        `DCM_R_BLKA: rdata_nxt = {16'h0000, blka_r};
        `DCM_R_AUX:  rdata_nxt = {16'h0000, aux_r};
        `DCM_R_ST0:  rdata_nxt = {16'h0000, st0};
        `DCM_R_ST1:  rdata_nxt = {16'h0000, st1};
        `DCM_R_RCNT: rdata_nxt = {16'h0000, rcnt_r};
        `DCM_R_STAT: rdata_nxt = {22'h000000, rarm_r, ract_r,
                                  pmode_r, sp_r, state_r};
        default:     rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // hardware stack storage, no reset needed for data
  always @(posedge CLK_SYS)
  begin
    if (stk_we)
      stk[stk_wa] <= stk_wd;
  end

  // state flops
  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_r     <= S_FETCH;
      instr_r     <= `DCM_RST_W16;
      sum_r       <= `DCM_RST_W32;
      prod_r      <= `DCM_RST_W32;
      treg_r      <= `DCM_RST_W16;
      tidx_r      <= `DCM_RST_W16;
      blka_r      <= `DCM_RST_W16;
      aux_r       <= `DCM_RST_W16;
      dp_r        <= 9'h000;
      ovm_r       <= `DCM_RST_FLAG;
      imask_r     <= `DCM_RST_IMASK;
      ramcfg_r    <= `DCM_RST_FLAG;
      sxm_r       <= `DCM_RST_FLAG;
      hm_r        <= `DCM_RST_FLAG;
      tflag_r     <= `DCM_RST_FLAG;
      c_r         <= `DCM_RST_FLAG;
      pmode_r     <= 2'h0;
      sp_r        <= 3'h0;
      rcnt_r      <= `DCM_RST_W16;
      rarm_r      <= 1'b0;
      ract_r      <= 1'b0;
      int_s1_r    <= 1'b0;
      int_s2_r    <= 1'b0;
      INSTR_READY <= 1'b0;
      DM_ADDR     <= `DCM_RST_W16;
      DM_RD       <= 1'b0;
      DM_WR       <= 1'b0;
      DM_WDATA    <= `DCM_RST_W16;
      PM_ADDR     <= `DCM_RST_W16;
      PM_RD       <= 1'b0;
      EXT_FLAG_PIN <= `DCM_RST_FLAG;
      IDLE_ACT    <= 1'b0;
      LOW_POWER   <= 1'b0;
      REG_RDATA   <= `DCM_RST_W32;
    end
    else
    begin
      state_r     <= state_nxt;
      instr_r     <= instr_nxt;
      sum_r       <= sum_nxt;
      prod_r      <= prod_nxt;
      treg_r      <= treg_nxt;
      tidx_r      <= tidx_nxt;
      blka_r      <= blka_nxt;
      aux_r       <= aux_nxt;
      dp_r        <= dp_nxt;
      ovm_r       <= ovm_nxt;
      imask_r     <= imask_nxt;
      ramcfg_r    <= ramcfg_nxt;
      sxm_r       <= sxm_nxt;
      hm_r        <= hm_nxt;
      tflag_r     <= tflag_nxt;
      c_r         <= c_nxt;
      pmode_r     <= pmode_nxt;
      sp_r        <= sp_nxt;
      rcnt_r      <= rcnt_nxt;
      rarm_r      <= rarm_nxt;
      ract_r      <= ract_nxt;
      int_s1_r    <= INT_REQ; // wake request synchroniser
      int_s2_r    <= int_s1_r;
      INSTR_READY <= ready_nxt;
      DM_ADDR     <= dm_addr_nxt;
      DM_RD       <= dm_rd_nxt;
      DM_WR       <= dm_wr_nxt;
      DM_WDATA    <= dm_wdata_nxt;
      PM_ADDR     <= pm_addr_nxt;
      PM_RD       <= pm_rd_nxt;
      EXT_FLAG_PIN <= pin_nxt;
      IDLE_ACT    <= idle_nxt;
      LOW_POWER   <= lowp_nxt;
      REG_RDATA   <= rdata_nxt;
    end
  end
endmodule // dcm_decoder
`default_nettype wire

// ==== verification/dcm_mem_model.sv ====
// data and program memory partner of the decoder
// assumes one clock; read data stand one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module dcm_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] dm_addr,
  input  wire logic        dm_rd,
  input  wire logic        dm_wr,
  input  wire logic [15:0] dm_wdata,
  output var  logic [15:0] dm_rdata,
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_rd,
  output var  logic [15:0] pm_rdata
);
  logic [15:0] mem  [0:255];
  logic [15:0] pmem [0:255];
  initial
  begin
    dm_rdata = 16'h0000;
    pm_rdata = 16'h0000;
  end
  // answer one cycle after a strobe, otherwise toggle so stale data never match
  always @(posedge clk)
  begin
    if (dm_wr)
      mem[dm_addr[7:0]] <= dm_wdata;
    dm_rdata <= dm_rd ? mem[dm_addr[7:0]] : ~dm_rdata;
    pm_rdata <= pm_rd ? pmem[pm_addr[7:0]] : ~pm_rdata;
  end
endmodule // dcm_mem_model
`default_nettype wire

// ==== verification/dcm_decoder_properties.sv ====
// timing properties of the decoder, bound to its ports
// assumes single clock CLK_SYS and async active-low RSTN
`timescale 1ns/1ps
`default_nettype none
module dcm_decoder_chk (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic [15:0] INSTR_WORD,
  input wire logic        INSTR_VALID,
  input wire logic        INSTR_READY,
  input wire logic [15:0] DM_ADDR,
  input wire logic        DM_RD,
  input wire logic        DM_WR,
  input wire logic        PM_RD,
  input wire logic        INT_REQ,
  input wire logic        EXT_FLAG_PIN,
  input wire logic        IDLE_ACT,
  input wire logic        LOW_POWER
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  // instruction handshake
  wire hs = INSTR_VALID && INSTR_READY;
  chk_pin_set: assert property (hs && INSTR_WORD == 16'hBE4D |=> EXT_FLAG_PIN && INSTR_READY)
    else $error("flag set op did not raise pin");
  chk_pin_clear: assert property (hs && INSTR_WORD == 16'hBE4C |=> !EXT_FLAG_PIN && INSTR_READY)
    else $error("flag clear op did not drop pin");
  chk_idle_plain: assert property (hs && INSTR_WORD == 16'hBE22 |=> IDLE_ACT && !LOW_POWER && !INSTR_READY)
    else $error("plain idle entry wrong");
  chk_idle_low: assert property (hs && INSTR_WORD == 16'hBE23 |=> IDLE_ACT && LOW_POWER)
    else $error("low power idle entry wrong");
  chk_idle_wake: assert property (IDLE_ACT && INT_REQ |-> ##[1:4] !IDLE_ACT)
    else $error("idle not left on interrupt");
  chk_idle_hold: assert property (IDLE_ACT && !INT_REQ && !$past(INT_REQ) && !$past(INT_REQ, 2) |=> IDLE_ACT)
    else $error("idle left without interrupt");
  chk_store_addr: assert property (hs && INSTR_WORD[15:9] == 7'h47 && !INSTR_WORD[7]
    |=> DM_WR && DM_ADDR[6:0] == $past(INSTR_WORD[6:0])) else $error("status store write wrong");
  chk_bit_read: assert property (hs && INSTR_WORD[15:8] == 8'h6F
    |=> DM_RD && !INSTR_READY ##1 !INSTR_READY ##1 INSTR_READY) else $error("indexed bit test timing");
  chk_coef_fetch: assert property (hs && INSTR_WORD[15:8] == 8'hAB |=> DM_RD && PM_RD)
    else $error("coefficient fetch missing");
  chk_rpt_wait: assert property (hs && INSTR_WORD[15:8] == 8'hBB |=> !INSTR_READY ##1 INSTR_READY)
    else $error("short repeat timing");
  cover property (hs && INSTR_WORD == 16'hBE23);
  cover property (hs && INSTR_WORD[15:8] == 8'hBB);
  cover property (DM_RD && PM_RD);
endmodule // dcm_decoder_chk
bind dcm_decoder dcm_decoder_chk u_chk (.CLK_SYS, .RSTN, .INSTR_WORD, .INSTR_VALID, .INSTR_READY, .DM_ADDR,
  .DM_RD, .DM_WR, .PM_RD, .INT_REQ, .EXT_FLAG_PIN, .IDLE_ACT, .LOW_POWER);
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench of the decoder
// assumes the memory partner model and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        CLK_SYS = 1'b0;
  logic        RSTN = 1'b0;
  logic [15:0] INSTR_WORD = 16'h0000;
  logic        INSTR_VALID = 1'b0;
  logic        INT_REQ = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [31:0] REG_RDATA, e0, e1;
  logic [15:0] DM_ADDR, DM_WDATA, DM_RDATA, PM_ADDR, PM_RDATA, pm_seen;
  logic        INSTR_READY, DM_RD, DM_WR, PM_RD, EXT_FLAG_PIN, IDLE_ACT, LOW_POWER;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_wr = 0;
  int          k;
  // flag rows: status register and bit of each target code
  logic [7:0]  t_addr [8] = '{8'h20, 8'h20, 8'h24, 8'h24, 8'h24, 8'h24, 8'h24, 8'h24};
  int          t_bit [8] = '{9, 11, 12, 10, 6, 11, 4, 9};

  always #12.5 CLK_SYS = ~CLK_SYS;

  dcm_decoder u_dut (.CLK_SYS, .RSTN, .INSTR_WORD, .INSTR_VALID, .INSTR_READY, .DM_ADDR, .DM_RD, .DM_WR,
    .DM_WDATA, .DM_RDATA, .PM_ADDR, .PM_RD, .PM_RDATA, .INT_REQ, .EXT_FLAG_PIN, .IDLE_ACT, .LOW_POWER,
    .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA);
  dcm_mem_model u_mem (.clk(CLK_SYS), .dm_addr(DM_ADDR), .dm_rd(DM_RD), .dm_wr(DM_WR), .dm_wdata(DM_WDATA),
    .dm_rdata(DM_RDATA), .pm_addr(PM_ADDR), .pm_rd(PM_RD), .pm_rdata(PM_RDATA));

  // count data writes, keep last coefficient address
  always @(posedge CLK_SYS)
  begin
    if (DM_WR === 1'b1)
      n_wr <= n_wr + 1;
    if (PM_RD === 1'b1)
      pm_seen <= PM_ADDR;
  end

  task automatic finish_test;
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic mchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    chk(nm, {16'h0000, e}, {16'h0000, u_mem.mem[a]});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= {16'h0000, d};
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1;
    chk(nm, e, REG_RDATA);
  endtask

  // bounded wait until the decoder takes words
  task automatic wait_rdy;
    int n;
    n = 0;
    while (INSTR_READY !== 1'b1)
    begin
      @(posedge CLK_SYS);
      #1;
      n++;
      if (n > 200)
      begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask

  task automatic issue(input logic [15:0] w);
    @(posedge CLK_SYS);
    INSTR_WORD <= w;
    INSTR_VALID <= 1'b1;
    #1;
    wait_rdy();
    @(posedge CLK_SYS);
    INSTR_VALID <= 1'b0;
  endtask

  task automatic op(input logic [15:0] w);
    issue(w);
    repeat (2) @(posedge CLK_SYS);
    #1;
    wait_rdy();
  endtask

  task automatic bt(input logic [15:0] w, input logic [15:0] x, input logic t);
    wr(8'h14, x);
    op(w);
    rdc("bit test", 8'h24, {20'h00000, t, 11'h000});
  endtask

  // repeat prefix, optional count word, then a store that is replayed
  task automatic rp(input logic [15:0] a, input logic [15:0] c, input logic two, input logic [31:0] n);
    int w0;
    w0 = n_wr;
    issue(a);
    if (two)
      issue(c);
    op(16'h8F1F);
    @(posedge CLK_SYS);
    #1;
    chk("repeat writes", n, n_wr - w0);
  endtask

  initial
  begin
    e0 = 32'h00000200;
    e1 = 32'h00000000;
    repeat (16) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    rdc("st0 reset", 8'h20, e0);
    rdc("st1 reset", 8'h24, e1);
    // every flag target cleared then set
    for (k = 0; k < 16; k++)
    begin
      op(16'hBE40 + k[15:0]);
      if (t_addr[k / 2] == 8'h20)
        e0[t_bit[k / 2]] = k[0];
      else
        e1[t_bit[k / 2]] = k[0];
      rdc("flag st0", 8'h20, e0);
      rdc("flag st1", 8'h24, e1);
      chk("flag pin", {31'h0, e1[4]}, {31'h0, EXT_FLAG_PIN});
    end
    // stores, direct and indirect
    wr(8'h1C, 16'h0030);
    op(16'h8E05);
    op(16'h8F06);
    op(16'h8E80);
    mchk("store st0", 8'h05, e0[15:0]);
    mchk("store st1", 8'h06, e1[15:0]);
    mchk("store ind", 8'h30, e0[15:0]);
    // loads move the data page to 1
    u_mem.mem[8'h10] = 16'h0201;
    u_mem.mem[8'h91] = 16'h0800;
    op(16'h0E10);
    op(16'h0F11);
    rdc("load st0", 8'h20, 32'h0201);
    rdc("load st1", 8'h24, 32'h0800);
    chk("pin load", 32'h0, {31'h0, EXT_FLAG_PIN});
    op(16'h8F07);
    mchk("page store", 8'h87, 16'h0800);
    // bit tests: number n picks data bit 15-n
    u_mem.mem[8'h92] = 16'h4000;
    bt(16'h4212, 16'h0000, 1'b0);
    bt(16'h4112, 16'h0000, 1'b1);
    bt(16'h6F12, 16'h0002, 1'b0);
    bt(16'h6F12, 16'h0011, 1'b1);
    // stack
    wr(8'h00, 16'h1234);
    wr(8'h04, 16'h55AA);
    u_mem.mem[8'h93] = 16'hBEEF;
    op(16'hBE3C);
    op(16'h7613);
    op(16'h8A14);
    mchk("pop mem", 8'h94, 16'hBEEF);
    wr(8'h00, 16'h0000);
    op(16'hBE32);
    rdc("pop sum", 8'h00, 32'h1234);
    rdc("sum high", 8'h04, 32'h55AA);
    // multiplies
    wr(8'h10, 16'h0003);
    op(16'hDFFF);
    rdc("imm lo", 8'h08, 32'hFFFD);
    rdc("imm hi", 8'h0C, 32'hFFFF);
    wr(8'h10, 16'hFFFF);
    u_mem.mem[8'h97] = 16'h0002;
    op(16'h5517);
    rdc("unsg lo", 8'h08, 32'hFFFE);
    rdc("unsg hi", 8'h0C, 32'h0001);
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0000);
    u_mem.mem[8'h98] = 16'h0004;
    op(16'h5218);
    rdc("sq sum lo", 8'h00, 32'hFFFE);
    rdc("sq sum hi", 8'h04, 32'h0001);
    rdc("sq prod", 8'h08, 32'h0010);
    rdc("sq mcnd", 8'h10, 32'h0004);
    op(16'hBF01);
    op(16'h5218);
    rdc("shift lo", 8'h00, 32'h001E);
    rdc("shift hi", 8'h04, 32'h0002);
    wr(8'h18, 16'h0077);
    u_mem.pmem[8'h77] = 16'h0005;
    u_mem.mem[8'h99] = 16'h0002;
    op(16'hAB19);
    chk("coef addr", 32'h0077, {16'h0, pm_seen});
    rdc("coef prod", 8'h08, 32'h000A);
    // repeats: count N gives N+1 runs
    u_mem.mem[8'h96] = 16'h0001;
    rp(16'hBB02, 16'h0000, 1'b0, 3);
    rp(16'h0B16, 16'h0000, 1'b0, 2);
    rp(16'hBEC4, 16'h0003, 1'b1, 4);
    rp(16'hBEC5, 16'h0000, 1'b1, 1);
    rdc("zero sum", 8'h00, 32'h0);
    rdc("zero prod", 8'h08, 32'h0);
    wr(8'h3C, 16'hFFFF);
    rdc("unmapped", 8'h3C, 32'h0);
    // both idle kinds, held until interrupt
    for (k = 0; k < 2; k++)
    begin
      issue(16'hBE22 + k[15:0]);
      repeat (20) @(posedge CLK_SYS);
      #1;
      chk("idle", {30'h0, k[0], 1'b1}, {30'h0, LOW_POWER, IDLE_ACT});
      chk("idle rdy", 32'h0, {31'h0, INSTR_READY});
      @(posedge CLK_SYS);
      INT_REQ <= 1'b1;
      #1;
      wait_rdy();
      chk("woken", 32'h0, {30'h0, LOW_POWER, IDLE_ACT});
      @(posedge CLK_SYS);
      INT_REQ <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
